// ===== src/audio_rx_top.sv
// Purpose: Clock detection, PLL fallback and sync watch for serial audio
// Assumes: rst_i is the power-on reset; the bit clock may stop between frames
// Notes:   Frame events cross by toggle; word data is stable when sampled
`timescale 1ns/1ps
`include "audio_rx_cfg.svh"
// Functional notes
// - Power-on reset, then initialization period
// - Detect sample rate family within tolerance
// - Set filter, modulator, pump clocks per rate
// - Ratios 128 and 192 only at rates above 48 kHz
// - Unsupported ratio and rate pairs unused
// - Sixteen good frames without clock start PLL
// - PLL off while external clock present
// - Three-wire port: word, bit, data
// - Sample data on bit clock rising edge
// - Accept 32, 24, 20, 16 bit words
// - Clock drift over five: reinit, zero
// - Bad framing over four: reinit, zero
// - Format input picks standard or left-justified
// - Left-justified: word clock high is left
module audio_rx_top
  import audio_rx_pkg::*;
#(
  parameter int unsigned FRAME_TMO_CYC = `FRAME_TMO_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bit_clock_i,
  input wire logic word_select_clock_i,
  input wire logic serial_data_i,
  input wire logic format_select_i,
  input wire logic sys_clock_i,
  output logic [31:0] left_data_o,
  output logic [31:0] right_data_o,
  output logic sample_valid_o,
  output logic bipolar_zero_o,
  output logic pll_enable_o,
  output logic init_done_o,
  output rate_t rate_o,
  output logic [1:0] filter_os_o,
  output logic [6:0] dsm_div_o,
  output logic [2:0] ncp_div_o
);

  localparam logic [15:0] INIT_CYC = 16'(`INIT_CYC);
  localparam logic [7:0] SCK_TMO = 8'(`SCK_TMO_CYC);
  localparam logic [15:0] PER_32K_LO = 16'(`PER_LO(`F_32K));

  logic [31:0] left_w;
  logic [31:0] right_w;
  logic frame_ok_w;
  logic frame_tgl_w;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic frame_evt;
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_s3_r;
  logic sck_rise;
  logic [7:0] sck_gap_r;
  logic sck_present_r;
  logic [15:0] init_cnt_r;
  logic [15:0] per_cnt_r;
  logic [12:0] sck_cnt_r;
  logic [12:0] ratio_lock_r;
  logic [16:0] tmo_cnt_r;
  logic [4:0] good_cnt_r;
  logic [2:0] bad_cnt_r;
  rate_t rate_now;
  logic [12:0] ratio_now;
  logic direct_ok;
  logic drift;
  logic bad_run;
  clk_mode_t mode_r;
  clk_mode_t mode_nxt;

  bit_clock_deserializer u_deser
  (
    .bit_clock_i(bit_clock_i),
    .rst_i(rst_i),
    .word_select_clock_i(word_select_clock_i),
    .serial_data_i(serial_data_i),
    .format_select_i(format_select_i),
    .left_word_o(left_w),
    .right_word_o(right_w),
    .frame_ok_o(frame_ok_w),
    .frame_tgl_o(frame_tgl_w)
  );

  function automatic rate_t rate_of(input logic [15:0] per);
    logic [31:0] p;
    p = 32'(per);
    if (p >= `PER_LO(`F_8K) && p <= `PER_HI(`F_8K))
      rate_of = RT_8K;
    else if (p >= `PER_LO(`F_16K) && p <= `PER_HI(`F_16K))
      rate_of = RT_16K;
    else if (p >= `PER_LO(`F_48K) && p <= `PER_HI(`F_32K))
      rate_of = RT_48K;
    else if (p >= `PER_LO(`F_96K) && p <= `PER_HI(`F_88K))
      rate_of = RT_96K;
    else if (p >= `PER_LO(`F_192K) && p <= `PER_HI(`F_176K))
      rate_of = RT_192K;
    else if (p >= `PER_LO(`F_384K) && p <= `PER_HI(`F_384K))
      rate_of = RT_384K;
    else
      rate_of = RT_NONE;
  endfunction : rate_of

  // Sampling the system clock costs an edge now and then; snap to the list
  function automatic logic [12:0] ratio_snap(input logic [12:0] n);
    logic [12:0] list [12];
    logic [12:0] d;
    list = '{13'd64, 13'd128, 13'd192, 13'd256, 13'd384, 13'd512,
             13'd768, 13'd1024, 13'd1152, 13'd1536, 13'd2048, 13'd3072};
    ratio_snap = 13'h0;
    for (int i = 0; i < 12; i++)
    begin
      d = (n > list[i]) ? n - list[i] : list[i] - n;
      if (d <= `RATIO_SNAP)
        ratio_snap = list[i];
    end
  endfunction : ratio_snap

  function automatic logic ratio_ok(input rate_t rt, input logic [12:0] r,
                                    input logic [15:0] per);
    logic [12:0] hi;
    logic [12:0] lo;
    case (rt)
      RT_8K, RT_16K: hi = 13'd3072;
      RT_48K: hi = (per >= PER_32K_LO) ? 13'd1536 : 13'd1024;
      RT_96K: hi = 13'd512;
      RT_192K: hi = 13'd256;
      RT_384K: hi = 13'd128;
      default: hi = 13'h0;
    endcase
    lo = (rt == RT_384K) ? 13'd64 : 13'd256;
    if (rt == RT_192K || (rt == RT_96K && r == 13'd192))
      lo = 13'd128;
    ratio_ok = (r != 13'h0) && r >= lo && r <= hi;
    if (r == 13'd1152 && rt > RT_16K && per < PER_32K_LO)
      ratio_ok = 1'b0;
    if (r == 13'd2048 && rt == RT_48K)
      ratio_ok = 1'b0;
  endfunction : ratio_ok

  assign rate_now = rate_of(per_cnt_r);
  assign ratio_now = ratio_snap(sck_cnt_r);
  assign direct_ok = sck_present_r && rate_now != RT_NONE &&
                     ratio_ok(rate_now, ratio_now, per_cnt_r);
  assign drift = (sck_cnt_r > ratio_lock_r + `SYNC_TOL_SCK) ||
                 (sck_cnt_r + `SYNC_TOL_SCK < ratio_lock_r);
  assign bad_run = !frame_ok_w && bad_cnt_r >= `BAD_FRAME_LIMIT;
  assign frame_evt = tgl_s2_r ^ tgl_s3_r;
  assign sck_rise = sck_s2_r & ~sck_s3_r;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
    end
    else
    begin
      tgl_s1_r <= frame_tgl_w;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      sck_s1_r <= sys_clock_i;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
    end
  end

  // System clock presence, and edges and ref cycles counted per frame
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sck_gap_r <= 8'h0;
      sck_present_r <= 1'b0;
      per_cnt_r <= 16'h0;
      sck_cnt_r <= 13'h0;
    end
    else
    begin
      if (sck_rise)
        sck_gap_r <= 8'h0;
      else if (sck_gap_r != 8'hff)
        sck_gap_r <= sck_gap_r + 8'h1;
      sck_present_r <= sck_rise || (sck_gap_r < SCK_TMO);
      if (frame_evt)
      begin
        per_cnt_r <= 16'h1;
        sck_cnt_r <= {12'h0, sck_rise};
      end
      else
      begin
        if (per_cnt_r != 16'hffff)
          per_cnt_r <= per_cnt_r + 16'h1;
        if (sck_rise && sck_cnt_r != 13'h1fff)
          sck_cnt_r <= sck_cnt_r + 13'h1;
      end
    end
  end

  // Initialization period after power-on reset
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      init_cnt_r <= 16'h0;
    else if (init_cnt_r != INIT_CYC)
      init_cnt_r <= init_cnt_r + 16'h1;
  end

  // Frame health: good run for the PLL, bad run and halt for resync
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      good_cnt_r <= 5'h0;
      bad_cnt_r <= 3'h0;
      tmo_cnt_r <= 17'h0;
    end
    else
    begin
      if (frame_evt || mode_r == CM_INIT)
        tmo_cnt_r <= 17'h0;
      else if (32'(tmo_cnt_r) < FRAME_TMO_CYC)
        tmo_cnt_r <= tmo_cnt_r + 17'h1;
      if (frame_evt)
      begin
        if (frame_ok_w)
          bad_cnt_r <= 3'h0;
        else if (bad_cnt_r != 3'h7)
          bad_cnt_r <= bad_cnt_r + 3'h1;
        if (frame_ok_w && !sck_present_r && rate_now != RT_NONE &&
            mode_r == CM_SEEK)
          good_cnt_r <= good_cnt_r + 5'h1;
        else
          good_cnt_r <= 5'h0;
      end
      else if (sck_present_r)
        good_cnt_r <= 5'h0;
    end
  end

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      CM_INIT:
        if (init_cnt_r == INIT_CYC)
          mode_nxt = CM_SEEK;
      CM_SEEK:
        if (frame_evt && frame_ok_w && direct_ok)
          mode_nxt = CM_EXT;
        else if (frame_evt && good_cnt_r == `PLL_LOCK_FRAMES - 5'h1 &&
                 frame_ok_w && !sck_present_r && rate_now != RT_NONE)
          mode_nxt = CM_PLL;
      CM_EXT:
        if (!sck_present_r || 32'(tmo_cnt_r) >= FRAME_TMO_CYC)
          mode_nxt = CM_SEEK;
        else if (frame_evt && (drift || bad_run))
          mode_nxt = CM_SEEK;
      CM_PLL:
        if (sck_present_r || 32'(tmo_cnt_r) >= FRAME_TMO_CYC)
          mode_nxt = CM_SEEK;
        else if (frame_evt && bad_run)
          mode_nxt = CM_SEEK;
      default:
        mode_nxt = CM_INIT;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      mode_r <= CM_INIT;
    else
      mode_r <= mode_nxt;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ratio_lock_r <= 13'h0;
    else if (mode_r == CM_SEEK && mode_nxt == CM_EXT)
      ratio_lock_r <= sck_cnt_r;
  end

  // Audio out: zero data whenever not locked, so the output sits at mid-scale
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left_data_o <= 32'h0;
      right_data_o <= 32'h0;
      sample_valid_o <= 1'b0;
      bipolar_zero_o <= 1'b1;
    end
    else
    begin
      bipolar_zero_o <= !(mode_nxt == CM_EXT || mode_nxt == CM_PLL);
      sample_valid_o <= frame_evt;
      // Loss can come between frames, so the zeroing cannot wait for one
      if (!(mode_nxt == CM_EXT || mode_nxt == CM_PLL))
      begin
        left_data_o <= 32'h0;
        right_data_o <= 32'h0;
      end
      else if (frame_evt)
      begin
        left_data_o <= left_w;
        right_data_o <= right_w;
      end
    end
  end

  // Clock plan for filter, modulator and charge pump, taken at lock
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pll_enable_o <= 1'b0;
      init_done_o <= 1'b0;
      rate_o <= RT_NONE;
      filter_os_o <= 2'h0;
      dsm_div_o <= 7'h0;
      ncp_div_o <= 3'h0;
    end
    else
    begin
      pll_enable_o <= (mode_nxt == CM_PLL);
      init_done_o <= (mode_r != CM_INIT);
      if (mode_r == CM_SEEK && mode_nxt != CM_SEEK)
      begin
        rate_o <= rate_now;
        case (rate_now)
          RT_96K: filter_os_o <= 2'h2;
          RT_192K: filter_os_o <= 2'h1;
          RT_384K: filter_os_o <= 2'h0;
          default: filter_os_o <= 2'h3;
        endcase
        if (mode_nxt == CM_EXT)
          dsm_div_o <= ratio_now[12:6];
        else
          dsm_div_o <= 7'(`PLL_SCK_RATIO >> 6);
        ncp_div_o <= 3'h7 - rate_now;
      end
      else if (mode_nxt == CM_SEEK)
        rate_o <= RT_NONE;
    end
  end

endmodule : audio_rx_top

// ===== inc/audio_rx_cfg.svh
// Purpose: Constants for the audio serial receiver and clock detector
// Assumes: Reference clock of 100 MHz
// Notes:   Frequencies in units of 100 Hz keep the arithmetic in 32 bits
`ifndef AUDIO_RX_CFG_SVH
`define AUDIO_RX_CFG_SVH

`define REF_CLK_MHZ 100
// Reference cycles per 100 Hz unit of frequency
`define REF_PER_UNIT 1000000
`define POR_THRESH_MV 2800
`define INIT_NS 1000
`define INIT_CYC ((`INIT_NS * `REF_CLK_MHZ) / 1000)
`define SCK_MAX_FREQ_MHZ 50
`define SCK_MAX_PER_NS 1000
// Two of the slowest system clock periods without an edge means absent
`define SCK_TMO_CYC ((2 * `SCK_MAX_PER_NS * `REF_CLK_MHZ) / 1000)
`define FRAME_TMO_NS 500000
`define FRAME_TMO_CYC ((`FRAME_TMO_NS / 1000) * `REF_CLK_MHZ)
`define TOL_PCT 4
// Period window for a rate f (100 Hz units), with tolerance
`define PER_LO(f) ((`REF_PER_UNIT * 100) / ((f) * (100 + `TOL_PCT)))
`define PER_HI(f) ((`REF_PER_UNIT * 100) / ((f) * (100 - `TOL_PCT)))
`define F_8K 80
`define F_16K 160
`define F_32K 320
`define F_48K 480
`define F_88K 882
`define F_96K 960
`define F_176K 1764
`define F_192K 1920
`define F_384K 3840
`define PLL_LOCK_FRAMES 5'd16
`define SYNC_TOL_SCK 13'd5
`define BAD_FRAME_LIMIT 3'd4
`define RATIO_SNAP 13'd2
`define PLL_SCK_RATIO 13'd256
`define WORD_MAX 6'd32
`define WORD_BITS_16 6'd16
`define WORD_BITS_20 6'd20
`define WORD_BITS_24 6'd24
`define WORD_BITS_32 6'd32

`endif

// ===== inc/audio_rx_pkg.sv
// Purpose: Types shared by the audio serial receiver
// Assumes: Nothing beyond the cfg header
// Notes:   Clock mode codes follow a Gray sequence along the usual path
package audio_rx_pkg;

  typedef enum logic [1:0]
  {
    CM_INIT = 2'b00,
    CM_SEEK = 2'b01,
    CM_EXT = 2'b11,
    CM_PLL = 2'b10
  } clk_mode_t;

  typedef enum logic [2:0]
  {
    RT_NONE = 3'h0,
    RT_8K = 3'h1,
    RT_16K = 3'h2,
    RT_48K = 3'h3,
    RT_96K = 3'h4,
    RT_192K = 3'h5,
    RT_384K = 3'h6
  } rate_t;

endpackage : audio_rx_pkg

// ===== src/bit_clock_deserializer.sv
// Purpose: Shift serial audio in on the bit clock, one frame at a time
// Assumes: Word select and data meet setup and hold to the bit clock
// Notes:   Words are left aligned in 32 bits, short words padded with zero
`timescale 1ns/1ps
`include "audio_rx_cfg.svh"
module bit_clock_deserializer
(
  input wire logic bit_clock_i,
  input wire logic rst_i,
  input wire logic word_select_clock_i,
  input wire logic serial_data_i,
  input wire logic format_select_i,
  output logic [31:0] left_word_o,
  output logic [31:0] right_word_o,
  output logic frame_ok_o,
  output logic frame_tgl_o
);

  logic ws_r;
  logic ws_p_r;
  logic din_r;
  logic fmt_s1_r;
  logic fmt_s2_r;
  logic left_q_r;
  logic left_now;
  logic [31:0] sh_r;
  logic [31:0] left_hold_r;
  logic [5:0] cnt_r;
  logic [5:0] left_bits_r;

  function automatic logic len_ok(input logic [5:0] n);
    len_ok = (n == `WORD_BITS_16) || (n == `WORD_BITS_20) ||
             (n == `WORD_BITS_24) || (n == `WORD_BITS_32);
  endfunction : len_ok

  always_ff @(posedge bit_clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ws_r <= 1'b0;
      ws_p_r <= 1'b0;
      din_r <= 1'b0;
      fmt_s1_r <= 1'b0;
      fmt_s2_r <= 1'b0;
    end
    else
    begin
      ws_r <= word_select_clock_i;
      ws_p_r <= ws_r;
      din_r <= serial_data_i;
      fmt_s1_r <= format_select_i;
      fmt_s2_r <= fmt_s1_r;
    end
  end

  // Standard framing is the left-justified case with word select inverted and one bit late
  assign left_now = fmt_s2_r ? ws_r : ~ws_p_r;

  always_ff @(posedge bit_clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left_q_r <= 1'b0;
      sh_r <= 32'h0;
      cnt_r <= 6'h0;
    end
    else
    begin
      left_q_r <= left_now;
      if (left_now != left_q_r)
      begin
        sh_r <= {din_r, 31'h0};
        cnt_r <= 6'h1;
      end
      else
      begin
        if (cnt_r < `WORD_MAX)
          sh_r <= sh_r | ({din_r, 31'h0} >> cnt_r);
        if (cnt_r != 6'h3f)
          cnt_r <= cnt_r + 6'h1;
      end
    end
  end

  // Both words publish together at the left edge; they hold a whole frame
  always_ff @(posedge bit_clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left_hold_r <= 32'h0;
      left_bits_r <= 6'h0;
      left_word_o <= 32'h0;
      right_word_o <= 32'h0;
      frame_ok_o <= 1'b0;
      frame_tgl_o <= 1'b0;
    end
    else if (left_now != left_q_r)
    begin
      if (left_now)
      begin
        left_word_o <= left_hold_r;
        right_word_o <= sh_r;
        frame_ok_o <= (cnt_r == left_bits_r) && len_ok(cnt_r);
        frame_tgl_o <= ~frame_tgl_o;
      end
      else
      begin
        left_hold_r <= sh_r;
        left_bits_r <= cnt_r;
      end
    end
  end

endmodule : bit_clock_deserializer

// ===== tb/audio_rx_monitor.sv
// Purpose: Port-level checks for the audio receiver top
// Assumes: All outputs are registers on ref_clk_i
// Notes:   Bound from the testbench file
`timescale 1ns/1ps
`include "audio_rx_cfg.svh"
module audio_rx_monitor
  import audio_rx_pkg::*;
#(
  parameter int unsigned FRAME_TMO_CYC = `FRAME_TMO_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bit_clock_i,
  input wire logic word_select_clock_i,
  input wire logic serial_data_i,
  input wire logic format_select_i,
  input wire logic sys_clock_i,
  input wire logic [31:0] left_data_o,
  input wire logic [31:0] right_data_o,
  input wire logic sample_valid_o,
  input wire logic bipolar_zero_o,
  input wire logic pll_enable_o,
  input wire logic init_done_o,
  input rate_t rate_o,
  input wire logic [1:0] filter_os_o,
  input wire logic [6:0] dsm_div_o,
  input wire logic [2:0] ncp_div_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [7:0] since_rst_r;

  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      since_rst_r <= 8'h00;
    else if (since_rst_r != 8'hff)
      since_rst_r <= since_rst_r + 8'h01;

  a_reset_state: assert property (disable iff (1'b0)
    rst_i |-> bipolar_zero_o && !init_done_o && !pll_enable_o)
    else $error("reset state wrong");
  a_init_early: assert property (init_done_o |-> since_rst_r >= 8'd100)
    else $error("init done too early");
  a_init_late: assert property (since_rst_r == 8'd110 |-> init_done_o)
    else $error("init done too late");
  a_valid_pulse: assert property (sample_valid_o |=> !sample_valid_o [*8])
    else $error("sample valid not a lone pulse");
  a_mute_zero: assert property (
    bipolar_zero_o && $past(bipolar_zero_o) |-> !(|{left_data_o, right_data_o}))
    else $error("data not zero while muted");
  a_lock_valid: assert property ($fell(bipolar_zero_o) |-> sample_valid_o)
    else $error("unmute without frame event");
  a_lock_ncp: assert property ($fell(bipolar_zero_o) |=>
    rate_o != RT_NONE && ncp_div_o == 3'd7 - 3'(rate_o))
    else $error("pump divider does not follow rate");
  a_pll_dsm: assert property (pll_enable_o && $past(pll_enable_o) |->
    dsm_div_o == 7'd4)
    else $error("modulator divider wrong in pll mode");
  a_pll_lock: assert property ($rose(pll_enable_o) |-> $fell(bipolar_zero_o))
    else $error("pll start without unmute");
  c_ext_lock: cover property ($fell(bipolar_zero_o) && !pll_enable_o);
  c_pll_lock: cover property ($rose(pll_enable_o));
  c_lost: cover property ($rose(bipolar_zero_o));
endmodule : audio_rx_monitor

// ===== tb/host_port_model.sv
// Purpose: Host serial port driving bit, word and system clocks
// Assumes: Bit clock runs only within frames and rests low between them
// Notes:   System clock stops while sck_half is zero
`timescale 1ns/1ps
module host_port_model
(
  output logic bit_clock_o,
  output logic word_select_o,
  output logic data_o,
  output logic sys_clock_o
);
  realtime sck_half = 0.0;
  realtime frame_ns = 1.0e9 / 96000.0;
  logic carry_bit = 1'b0;

  initial
  begin
    bit_clock_o = 1'b0;
    word_select_o = 1'b0;
    data_o = 1'b0;
  end

  // Derived from the word rate so both stay frequency locked
  always
  begin
    if (sck_half > 0.0)
    begin
      #(sck_half);
      sys_clock_o = ~sys_clock_o;
    end
    else
    begin
      sys_clock_o = 1'b0;
      #10;
    end
  end

  task automatic send_frame(input logic lj, input int hl, input int hr,
    input logic [31:0] l, input logic [31:0] r);
    realtime t0;
    logic d;
    t0 = $realtime;
    for (int i = 0; i < hl + hr; i++)
    begin
      word_select_o = (i < hl) ? lj : ~lj;
      if (lj)
        d = (i < hl) ? l[31 - i] : r[31 - (i - hl)];
      else if (i == 0)
        d = carry_bit;
      else
        d = (i <= hl) ? l[32 - i] : r[32 - (i - hl)];
      data_o = d;
      #7.5 bit_clock_o = 1'b1;
      #7.5 bit_clock_o = 1'b0;
    end
    carry_bit = r[32 - hr];
    // Hold time over: show the opposite level, never a stale bit
    data_o = ~d;
    #(frame_ns - ($realtime - t0));
  endtask : send_frame
endmodule : host_port_model

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the audio receiver top
// Assumes: Host paces 96 kHz frames with a gapped 15 ns bit clock
// Notes:   Expected words are the bench's own copies of what was sent
`timescale 1ns/1ps
module testbench
  import audio_rx_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i;
  logic format_select_i = 1'b1;
  logic bit_clock_i, word_select_clock_i, serial_data_i, sys_clock_i;
  logic [31:0] left_data_o, right_data_o, exp_l, exp_r, pend_l, pend_r;
  logic sample_valid_o, bipolar_zero_o, pll_enable_o, init_done_o;
  rate_t rate_o;
  logic [1:0] filter_os_o;
  logic [6:0] dsm_div_o;
  logic [2:0] ncp_div_o;
  logic chk = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  host_port_model i_host_port_model (.bit_clock_o(bit_clock_i),
    .word_select_o(word_select_clock_i), .data_o(serial_data_i),
    .sys_clock_o(sys_clock_i));

  audio_rx_top #(.FRAME_TMO_CYC(2000)) i_audio_rx_top (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .bit_clock_i(bit_clock_i),
    .word_select_clock_i(word_select_clock_i), .serial_data_i(serial_data_i),
    .format_select_i(format_select_i), .sys_clock_i(sys_clock_i),
    .left_data_o(left_data_o), .right_data_o(right_data_o),
    .sample_valid_o(sample_valid_o), .bipolar_zero_o(bipolar_zero_o),
    .pll_enable_o(pll_enable_o), .init_done_o(init_done_o), .rate_o(rate_o),
    .filter_os_o(filter_os_o), .dsm_div_o(dsm_div_o), .ncp_div_o(ncp_div_o));

  task automatic complete_run();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic set_sck(input real ratio);
    i_host_port_model.sck_half = (ratio > 0.0) ?
      1.0e9 / (96000.0 * 2.0 * ratio) : 0.0;
  endtask : set_sck

  task automatic frames(input int n, input int wl, input int wr);
    for (int k = 0; k < n; k++)
    begin
      exp_l = pend_l;
      exp_r = pend_r;
      pend_l = $urandom() & ~(32'hffff_ffff >> wl);
      pend_r = $urandom() & ~(32'hffff_ffff >> wr);
      i_host_port_model.send_frame(format_select_i, wl, wr, pend_l, pend_r);
    end
    @(negedge ref_clk_i);
  endtask : frames

  // Published words must match the last completed frame, left aligned
  always @(negedge ref_clk_i)
    if (sample_valid_o === 1'b1 && bipolar_zero_o === 1'b0 && chk)
    begin
      check("left_data_o", exp_l, left_data_o);
      check("right_data_o", exp_r, right_data_o);
    end

  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 75000)
    begin
      miscompares++;
      complete_run();
    end
  end

  initial
  begin
    void'($urandom(32'hf3b1));
    // Raised at time zero by a nonblocking write so the asynchronous resets see an edge
    rst_i <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (95) @(negedge ref_clk_i);
    check("init_done_o", 0, init_done_o);
    repeat (15) @(negedge ref_clk_i);
    check("init_done_o", 1, init_done_o);
    set_sck(128.0);
    frames(10, 24, 24);
    check("bipolar_zero_o", 1, bipolar_zero_o);
    set_sck(256.0);
    chk = 1'b1;
    frames(3, 32, 32);
    frames(2, 24, 24);
    frames(2, 16, 16);
    check("bipolar_zero_o", 0, bipolar_zero_o);
    check("pll_enable_o", 0, pll_enable_o);
    check("rate_o", RT_96K, rate_o);
    check("filter_os_o", 2, filter_os_o);
    check("dsm_div_o", 4, dsm_div_o);
    check("ncp_div_o", 3, ncp_div_o);
    chk = 1'b0;
    set_sck(264.0);
    frames(3, 24, 24);
    check("bipolar_zero_o", 1, bipolar_zero_o);
    set_sck(0.0);
    frames(15, 24, 24);
    check("pll_enable_o", 0, pll_enable_o);
    frames(3, 24, 24);
    check("pll_enable_o", 1, pll_enable_o);
    chk = 1'b1;
    frames(2, 32, 32);
    chk = 1'b0;
    @(posedge ref_clk_i);
    format_select_i <= 1'b0;
    @(posedge ref_clk_i);
    frames(2, 16, 16);
    chk = 1'b1;
    frames(3, 16, 16);
    set_sck(256.0);
    frames(4, 24, 24);
    check("pll_enable_o", 0, pll_enable_o);
    chk = 1'b0;
    frames(5, 16, 24);
    check("bipolar_zero_o", 0, bipolar_zero_o);
    frames(1, 16, 16);
    check("bipolar_zero_o", 1, bipolar_zero_o);
    complete_run();
  end
endmodule : testbench

bind audio_rx_top audio_rx_monitor #(.FRAME_TMO_CYC(FRAME_TMO_CYC))
  i_audio_rx_monitor (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .bit_clock_i(bit_clock_i), .word_select_clock_i(word_select_clock_i),
  .serial_data_i(serial_data_i), .format_select_i(format_select_i),
  .sys_clock_i(sys_clock_i), .left_data_o(left_data_o),
  .right_data_o(right_data_o), .sample_valid_o(sample_valid_o),
  .bipolar_zero_o(bipolar_zero_o), .pll_enable_o(pll_enable_o),
  .init_done_o(init_done_o), .rate_o(rate_o), .filter_os_o(filter_os_o),
  .dsm_div_o(dsm_div_o), .ncp_div_o(ncp_div_o));
